// *** verilog/cads_defs.vh ***
// Purpose: Constants for the address decode and I/O select block.
// Assumes: 16-bit processor address bus, 8-bit port numbers.
// Notes: Definitions only.
`ifndef CADS_DEFS_VH
`define CADS_DEFS_VH
`define CADS_ADDR_W 16
`define CADS_PORT_W 8
`define CADS_TOP_BIT 4'hf
`define CADS_MAP_ISOLATED 1'b0
`define CADS_MAP_MEMORY 1'b1
`define CADS_MEM_CS_N 8
`define CADS_MEM_SEL_LSB 12
`define CADS_IO_CS_N 8
`define CADS_IO_SEL_LSB 4
`define CADS_LINEAR_LSB 0
`define CADS_LINEAR_W 8
`define CADS_ADDR_RST 16'h0000
`define CADS_OE_RST 1'b0
`define CADS_STROBE_IDLE_N 1'b1
`define CADS_CS_IDLE_N 8'hff
`endif

// *** verilog/cads_decode.v ***
// Purpose: Address bus buffering, chip-select decode and I/O mode selection.
// Assumes: Processor strobes are active low and arrive on the clk domain.
// Notes: Outputs are registered, so selects follow the bus by one clock.
//   Linear select picks the lowest set bit if software sets more than one.
//   The address enable only qualifies the pad driver, which sits outside this block.
//
// Summary of operation
// [RULE1] Address buffers float whenever bus release request is high.
// [RULE2] Address bus is 16 bits, reaching 65k bytes of memory.
// [RULE3] Isolated mode selects 256 input and 256 output ports by I/O strobes.
// [RULE4] Isolated mode separates memory from I/O by strobes only; full range to memory.
// [RULE5] Decode a subset of address bits into chip-select outputs.
// [RULE6] Optional linear select: one address bit enables one I/O device.
// [RULE7] Mapped mode makes I/O strobes by gating memory strobes with gating bit.
// [RULE8] Mapped mode: memory while gating bit low, I/O only while high.
// [RULE9] Gating bit defaults to the top bit, limiting memory to 32k; selectable. The code has no default: gate_bit_sel alone picks the bit.
// [RULE10] Mapped I/O strobes drive I/O devices like isolated strobes.
// [RULE11] Memory strobes are active low; reads drive, writes latch while low.
// [RULE12] At most one chip select active for any address and strobe.
`include "cads_defs.vh"
`default_nettype none
module cads_decode (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Configuration
  input wire map_mode,
  input wire [3:0] gate_bit_sel,
  input wire linear_mode,
  // Processor side
  input wire bus_release_request,
  input wire [`CADS_ADDR_W-1:0] cpu_addr,
  input wire mem_rd_n,
  input wire mem_wr_n,
  input wire io_rd_n,
  input wire io_wr_n,
  // Buffered address bus
  output wire [`CADS_ADDR_W-1:0] addr_out,
  output wire addr_oe,
  // Device side strobes
  output wire dev_mem_rd_n,
  output wire dev_mem_wr_n,
  output wire io_read_n,
  output wire io_write_n,
  output wire mapped_io_read_strobe,
  output wire mapped_io_write_strobe,
  // Chip selects
  output wire [`CADS_MEM_CS_N-1:0] mem_cs_n,
  output wire [`CADS_IO_CS_N-1:0] io_cs_n
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // One-hot active-low decode of a 3-bit field; one call for the memory bank, two for the I/O bank.
  function [7:0] cads_onehot_n;
    input [2:0] idx;
    input en;
    begin
      cads_onehot_n = `CADS_CS_IDLE_N;
      if (en) begin
        cads_onehot_n[idx] = 1'b0; // RULE12
      end
    end
  endfunction

  // Passes an active-low strobe only while its enable is high.
  function cads_gate_n;
    input strobe_n;
    input en;
    begin
      cads_gate_n = ~(~strobe_n & en);
    end
  endfunction

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  wire gate_bit;
  wire mem_access;
  wire io_access;
  wire io_rd_any;
  wire io_wr_any;
  wire [2:0] mem_field;
  wire [2:0] io_field;
  wire [`CADS_LINEAR_W-1:0] lin_field;
  wire mapped_en;
  reg [7:0] io_cs_next;
  reg [7:0] lin_n;
  integer i;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign gate_bit = cpu_addr[gate_bit_sel]; // RULE9
  // A mapped port access needs both the mode and the gating bit.
  assign mapped_en = gate_bit & map_mode; // RULE7
  // In mapped mode the gating bit splits the space; isolated keeps all 64k for memory.
  assign mem_access = (map_mode == `CADS_MAP_MEMORY) ? ~gate_bit : 1'b1; // RULE4 RULE8
  assign io_rd_any = (map_mode == `CADS_MAP_MEMORY) ? (~mem_rd_n & gate_bit) : ~io_rd_n; // RULE7
  assign io_wr_any = (map_mode == `CADS_MAP_MEMORY) ? (~mem_wr_n & gate_bit) : ~io_wr_n; // RULE7
  assign io_access = io_rd_any | io_wr_any; // RULE3
  assign mem_field = cpu_addr[`CADS_MEM_SEL_LSB+2:`CADS_MEM_SEL_LSB];
  assign io_field = cpu_addr[`CADS_IO_SEL_LSB+2:`CADS_IO_SEL_LSB];
  assign lin_field = cpu_addr[`CADS_LINEAR_LSB+`CADS_LINEAR_W-1:`CADS_LINEAR_LSB];

  // ----------------------------------------
  // Select decode
  // ----------------------------------------
  always @* begin
    lin_n = `CADS_CS_IDLE_N;
    // Linear select trusts software to set only one port bit; a priority pick keeps one-hot.
    for (i = `CADS_LINEAR_W-1; i >= 0; i = i - 1) begin
      if (lin_field[i]) begin
        lin_n = cads_onehot_n(i[2:0], io_access); // RULE6 RULE12
      end
    end
    if (linear_mode) begin
      io_cs_next = lin_n;
    end else begin
      io_cs_next = cads_onehot_n(io_field, io_access); // RULE5
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Every output leaves from a flop so the selects never glitch while the address settles.
  reg [`CADS_ADDR_W-1:0] addr_reg;
  reg [`CADS_ADDR_W-1:0] addr_next;
  reg addr_oe_reg;
  reg addr_oe_next;
  reg dev_mem_rd_n_reg;
  reg dev_mem_rd_n_next;
  reg dev_mem_wr_n_reg;
  reg dev_mem_wr_n_next;
  reg io_read_n_reg;
  reg io_read_n_next;
  reg io_write_n_reg;
  reg io_write_n_next;
  reg mapped_rd_n_reg;
  reg mapped_rd_n_next;
  reg mapped_wr_n_reg;
  reg mapped_wr_n_next;
  reg [`CADS_MEM_CS_N-1:0] mem_cs_n_reg;
  reg [`CADS_MEM_CS_N-1:0] mem_cs_n_next;
  reg [`CADS_IO_CS_N-1:0] io_cs_n_reg;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always @* begin
    addr_next = cpu_addr; // RULE2
    addr_oe_next = ~bus_release_request; // RULE1
  end

  // The one-cycle lag is the price of glitch-free selects.
  always @* begin
    dev_mem_rd_n_next = cads_gate_n(mem_rd_n, mem_access); // RULE8 RULE11
    dev_mem_wr_n_next = cads_gate_n(mem_wr_n, mem_access); // RULE8 RULE11
    io_read_n_next = ~io_rd_any; // RULE10
    io_write_n_next = ~io_wr_any; // RULE10
    mapped_rd_n_next = cads_gate_n(mem_rd_n, mapped_en); // RULE7
    mapped_wr_n_next = cads_gate_n(mem_wr_n, mapped_en); // RULE7
  end

  // A memory select never shares a cycle with an I/O select.
  always @* begin
    mem_cs_n_next = cads_onehot_n(mem_field,
      mem_access & ~io_access & (~mem_rd_n | ~mem_wr_n)); // RULE5 RULE12
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  // Reset leaves the address undriven so another master may own the bus at power-up.
  always @(posedge clk) begin
    if (!rst_n) begin
      addr_reg <= `CADS_ADDR_RST;
      addr_oe_reg <= `CADS_OE_RST;
    end else begin
      addr_reg <= addr_next;
      addr_oe_reg <= addr_oe_next;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      dev_mem_rd_n_reg <= `CADS_STROBE_IDLE_N;
      dev_mem_wr_n_reg <= `CADS_STROBE_IDLE_N;
      io_read_n_reg <= `CADS_STROBE_IDLE_N;
      io_write_n_reg <= `CADS_STROBE_IDLE_N;
      mapped_rd_n_reg <= `CADS_STROBE_IDLE_N;
      mapped_wr_n_reg <= `CADS_STROBE_IDLE_N;
      mem_cs_n_reg <= `CADS_CS_IDLE_N;
      io_cs_n_reg <= `CADS_CS_IDLE_N;
    end else begin
      dev_mem_rd_n_reg <= dev_mem_rd_n_next;
      dev_mem_wr_n_reg <= dev_mem_wr_n_next;
      io_read_n_reg <= io_read_n_next;
      io_write_n_reg <= io_write_n_next;
      mapped_rd_n_reg <= mapped_rd_n_next;
      mapped_wr_n_reg <= mapped_wr_n_next;
      mem_cs_n_reg <= mem_cs_n_next;
      io_cs_n_reg <= io_cs_next; // RULE3
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign addr_out = addr_reg;
  assign addr_oe = addr_oe_reg;
  assign dev_mem_rd_n = dev_mem_rd_n_reg;
  assign dev_mem_wr_n = dev_mem_wr_n_reg;
  assign io_read_n = io_read_n_reg;
  assign io_write_n = io_write_n_reg;
  assign mapped_io_read_strobe = mapped_rd_n_reg;
  assign mapped_io_write_strobe = mapped_wr_n_reg;
  assign mem_cs_n = mem_cs_n_reg;
  assign io_cs_n = io_cs_n_reg;

endmodule
`default_nettype wire

// *** bench/cads_cpu_model.sv ***
// Purpose: Processor bus model driving address and strobes.
// Assumes: One bus cycle per clock.
// Notes: Strobes are active low.
`default_nettype none
module cads_cpu_model (
  // Processor bus
  input wire logic clk,
  output logic [15:0] cpu_addr,
  output logic [3:0] strb_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cpu_addr, strb_n} = {16'h0000, 4'hf};
  // Order is read, write, port read, port write; changed just after an edge.
  task automatic op(input logic [15:0] a, input logic [3:0] s);
    @(posedge clk) #1;
    cpu_addr = a;
    strb_n = s;
  endtask
endmodule
`default_nettype wire

// *** bench/cads_decode_props.sv ***
// Purpose: Port checker for cads_decode.
// Assumes: Outputs lag inputs by one clock.
// Notes: Bound at the foot of this file.
`default_nettype none
module cads_decode_props (
  // Watched ports
  input wire logic clk, rst_n, map_mode, bus_release_request, mem_rd_n, mem_wr_n, io_rd_n,
  input wire logic io_wr_n, addr_oe, dev_mem_rd_n, dev_mem_wr_n, io_read_n,
  input wire logic mapped_io_read_strobe, mapped_io_write_strobe,
  input wire logic [3:0] gate_bit_sel,
  input wire logic [15:0] cpu_addr, addr_out,
  input wire logic [7:0] mem_cs_n, io_cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Plain copies of the gating bit and memory field, so $past sees signals.
  logic gate_now;
  logic [2:0] mem_field_now;
  assign gate_now = cpu_addr[gate_bit_sel];
  assign mem_field_now = cpu_addr[14:12];
  // The first edge after reset still shows reset outputs, so it is skipped.
  logic up = 1'b0;
  always @(posedge clk) up <= rst_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !up);
  a_bus_release: assert property (addr_oe == !$past(bus_release_request))
    else $error("address enable wrong");
  a_addr_copy: assert property (addr_out == $past(cpu_addr)) else $error("address wrong");
  a_iso_strobe: assert property (!$past(map_mode) |-> io_read_n == $past(io_rd_n))
    else $error("port read strobe wrong");
  a_mem_decode: assert property (!$past(map_mode) && !$past(mem_rd_n) && $past(io_rd_n)
    && $past(io_wr_n) |-> mem_cs_n == ~(8'h01 << $past(mem_field_now)))
    else $error("memory select wrong");
  a_mapped_read: assert property ($past(map_mode) |-> mapped_io_read_strobe ==
    ($past(mem_rd_n) || !$past(gate_now))) else $error("mapped read wrong");
  a_mapped_write: assert property ($past(map_mode) |-> mapped_io_write_strobe ==
    ($past(mem_wr_n) || !$past(gate_now))) else $error("mapped write wrong");
  a_mem_block: assert property ($past(map_mode) && $past(gate_now)
    |-> dev_mem_rd_n && dev_mem_wr_n && mem_cs_n == 8'hff) else $error("memory not blocked");
  a_same_strobe: assert property ($past(map_mode) |-> io_read_n == mapped_io_read_strobe)
    else $error("port strobe differs");
  a_one_select: assert property ($countones(~{mem_cs_n, io_cs_n}) < 2)
    else $error("two selects active");
endmodule
bind cads_decode cads_decode_props props (.*);
`default_nettype wire

// *** bench/cads_decode_bench.sv ***
// Purpose: Self-checking bench for cads_decode.
// Assumes: 20 ns clock, synchronous active-low reset.
// Notes: Each result is read one clock after its bus cycle.
`default_nettype none
module cads_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, mm = 1'h0, lm = 1'h0, rq = 1'h1;
  logic oe, mr, mw, ir, iw, mir, miw;
  logic [3:0] gb = 4'hf, s;
  logic [7:0] mc, ic;
  logic [15:0] a, ao;
  int bad_count = 0, samples_checked = 0;
  always #10 clk = ~clk;
  cads_cpu_model u (.clk(clk), .cpu_addr(a), .strb_n(s));
  cads_decode DUT (.clk(clk), .rst_n(rst_n), .map_mode(mm), .gate_bit_sel(gb), .linear_mode(lm),
    .bus_release_request(rq), .cpu_addr(a), .mem_rd_n(s[3]), .mem_wr_n(s[2]), .io_rd_n(s[1]),
    .io_wr_n(s[0]), .addr_out(ao), .addr_oe(oe), .dev_mem_rd_n(mr), .dev_mem_wr_n(mw),
    .io_read_n(ir), .io_write_n(iw), .mapped_io_read_strobe(mir), .mapped_io_write_strobe(miw),
    .mem_cs_n(mc), .io_cs_n(ic));
  task automatic chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  task automatic go(input logic [15:0] ad, input logic [3:0] st);
    u.op(ad, st);
    @(posedge clk) #1;
  endtask
  task automatic t_iso;
    go(16'h3000, 4'hb);
    chk(mc, 8'hf7);
    chk(mw, 1'h0);
    chk(ao, 16'h3000);
    chk(oe, 1'h0);
    chk(mir, 1'h1);
    go(16'hb000, 4'h7);
    chk(mc, 8'hf7);
    chk(mr, 1'h0);
    rq = 1'h0;
    go(16'h0020, 4'hd);
    chk(ic, 8'hfb);
    chk(ir, 1'h0);
    chk(iw, 1'h1);
    chk(mc, 8'hff);
    chk(oe, 1'h1);
  endtask
  task automatic t_map;
    mm = 1'h1;
    go(16'h0000, 4'he);
    chk(iw, 1'h1);
    chk(ic, 8'hff);
    go(16'h8000, 4'h7);
    chk(mir, 1'h0);
    chk(ic, 8'hfe);
    chk(mr, 1'h1);
    go(16'h7000, 4'hb);
    chk(mc, 8'h7f);
    gb = 4'h0;
    go(16'h0001, 4'hb);
    chk(miw, 1'h0);
    chk(iw, 1'h0);
  endtask
  task automatic t_lin;
    mm = 1'h0;
    lm = 1'h1;
    go(16'h0028, 4'hd);
    chk(ic, 8'hf7);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'h1;
    t_iso;
    t_map;
    t_lin;
    finish_test;
  end
  // The whole run needs under fifty clocks; this is ample margin.
  initial begin
    #4000;
    bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
